// ### dv/pll_clock_multiplier_config_tb_top.sv
// Self-checking bench for the clock multiplier config block.
// Assumes one waitrequest-low answer cycle and derived outputs one clock behind.
`default_nettype none

module pll_clock_multiplier_config_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pll_cfg_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic busy = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [3:0] be = 4'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic [2:0] auto_code = 3'h0;
  logic [31:0] q;
  logic [31:0] rdata;
  logic wait_req, div_rst, dbl_act, dbl_en, pll_en, cp_man;
  logic [3:0] factor;
  logic [8:0] mult;
  logic [2:0] cp_cur;
  int n_fail = 0;
  int total_checks = 0;
  int pulse_len = 0;

  // 125 MHz core clock
  always #4 clk = ~clk;

  // Count cycles of divider reset
  always @(posedge clk) if (div_rst === 1'b1) pulse_len <= pulse_len + 1;

  pll_clock_multiplier_config DUT (
    .i_core_clk(clk), .i_sys_rst(rst), .i_address(addr), .i_read(rd), .i_write(wr),
    .i_byteenable(be), .i_writedata(wd), .o_readdata(rdata), .o_waitrequest(wait_req),
    .i_vco_cal_busy(busy), .i_cp_auto_code(auto_code), .o_ref_div_reset(div_rst),
    .o_ref_div_factor(factor), .o_doubler_active(dbl_act), .o_doubler_circuit_en(dbl_en),
    .o_pll_enable(pll_en), .o_pll_mult(mult), .o_cp_manual(cp_man),
    .o_charge_pump_current(cp_cur)
  );

  // Verdict and end of run
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compare one value
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One Avalon-MM transfer, held until waitrequest is sampled low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    int k;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wd <= d;
    be <= b;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wait_req !== 1'b0 && k < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_req !== 1'b0) begin
      n_fail++;
      $display("MISMATCH t=%0t bus answer timed out", $time);
      summarize();
    end
  endtask

  // Full-word config write, then let derived outputs settle
  task cfg(input logic [31:0] d);
    bus(1'b1, CFG_ADDR, d, 4'hF);
    repeat (2) @(posedge clk);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(mult, 32'h0000_0032);
    chk(cp_man, 32'h0);
    bus(1'b0, CFG_ADDR, 32'h0, 4'h0);
    chk(q, 32'h0000_1900);
    cfg(32'hFFFF_FFFF);
    bus(1'b0, CFG_ADDR, 32'h0, 4'h0);
    chk(q, 32'h007F_FF78);
    chk(factor, 32'h8);
    chk(mult, 32'h0000_01FE);
    chk(cp_man, 32'h1);
    chk(cp_cur, 32'h7);
    repeat (8) @(posedge clk);
    pulse_len = 0;
    cfg(32'h0040_1900);
    repeat (6) @(posedge clk);
    chk(pulse_len, 32'h4);
    cfg(32'h0000_1900);
    bus(1'b1, CFG_ADDR, 32'h0040_1900, 4'hB); // lane 1 keeps legal N
    repeat (6) @(posedge clk);
    chk(pulse_len, 32'h4);
    // Every divider code, enabled and bypassed
    for (int i = 0; i < 8; i++) begin
      cfg({9'h000, 1'b0, i[1:0], 2'b00, i[2], 1'b0, 8'h19, 8'h00});
      chk(factor, i[2] ? (32'h1 << i[1:0]) : 32'h1);
    end
    // Doubler bit pairs with PLL enable alongside
    for (int i = 0; i < 4; i++) begin
      cfg({12'h000, i[1], ~i[1], 1'b0, i[0], 8'h19, 8'h00});
      chk(dbl_act, i == 3);
      chk(dbl_en, i[0]);
      chk(pll_en, !i[1]);
    end
    cfg(32'h0000_0A00); // lowest legal N
    chk(mult, 32'h0000_0014);
    // Automatic pump current kept after calibration ends
    cfg(32'h0004_1928);
    auto_code <= 3'h3;
    busy <= 1'b1; // calibration follows PLL enable
    repeat (3) @(posedge clk);
    busy <= 1'b0;
    auto_code <= 3'h6;
    repeat (3) @(posedge clk);
    chk(cp_man, 32'h0);
    chk(cp_cur, 32'h3);
    chk(pll_en, 32'h1);
    bus(1'b0, STATUS_ADDR, 32'h0, 4'h0);
    chk(q, 32'h0000_004C);
    bus(1'b0, 8'h40, 32'h0, 4'h0);
    chk(q, 32'h0);
    summarize();
  end

endmodule

`default_nettype wire

// ### hdl/div_reset_pulse.sv
// Fixed-length pulse generator for the reference input divider reset.
// Assumes a one-cycle trigger in the core clock domain.
`default_nettype none

module div_reset_pulse
  import pll_cfg_pkg::*;
(
  input wire logic i_core_clk, // Core clock
  input wire logic i_sys_rst, // Synchronous reset, high
  input wire logic i_trigger, // One-cycle start request
  output logic o_pulse // Divider reset, registered
);

  logic [RST_CNT_W-1:0] remain;

  // Load on trigger, count down, pulse while counting
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      remain <= '0;
      o_pulse <= 1'b0;
    end else if (i_trigger) begin
      remain <= DIV_RST_CYC - 3'h1;
      o_pulse <= 1'b1;
    end else if (remain != '0) begin
      remain <= remain - 3'h1;
      o_pulse <= 1'b1;
    end else begin
      o_pulse <= 1'b0;
    end
  end

  // Retrigger restarts, so the pulse spans four cycles after the last start
  a_pulse_length: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_trigger |=> o_pulse [*4])
    else $error("divider reset pulse too short");

endmodule

`default_nettype wire

// ### hdl/pll_cfg_pkg.sv
// Constants, field layout and helpers for the clock multiplier config block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
`default_nettype none

package pll_cfg_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = 4;

  // Register index and byte addresses
  localparam logic [7:0] CFG_INDEX = 8'h02;
  localparam logic [7:0] CFG_ADDR = {CFG_INDEX[5:0], 2'b00};
  localparam logic [7:0] STATUS_ADDR = 8'h0C;

  // Field positions of the config word
  localparam int unsigned DIV_RST_BIT = 22;
  localparam int unsigned DIV_SEL_LSB = 20;
  localparam int unsigned DBL_EN_BIT = 19;
  localparam int unsigned PLL_EN_BIT = 18;
  localparam int unsigned DIV_EN_BIT = 17;
  localparam int unsigned DBL_EDGE_BIT = 16;
  localparam int unsigned FB_LSB = 8;
  localparam int unsigned FB_W = 8;
  localparam int unsigned CP_MAN_BIT = 6;
  localparam int unsigned CP_LSB = 3;
  localparam int unsigned CP_W = 3;
  localparam int unsigned DIV_RST_LANE = 2;

  // Writable bits; everything else reads zero
  localparam logic [31:0] CFG_WR_MASK = 32'h007F_FF78;
  localparam logic [7:0] FB_DEFAULT = 8'h19;
  localparam logic [31:0] CFG_RESET = {16'h0000, FB_DEFAULT, 8'h00};

  // Divider select codes and factors
  localparam logic [1:0] DIV_SEL_1 = 2'h0;
  localparam logic [1:0] DIV_SEL_2 = 2'h1;
  localparam logic [1:0] DIV_SEL_4 = 2'h2;
  localparam logic [3:0] FACTOR_1 = 4'h1;
  localparam logic [3:0] FACTOR_2 = 4'h2;
  localparam logic [3:0] FACTOR_4 = 4'h4;
  localparam logic [3:0] FACTOR_8 = 4'h8;

  // Reference divider reset pulse length in core clocks
  localparam int unsigned RST_CNT_W = 3;
  localparam logic [RST_CNT_W-1:0] DIV_RST_CYC = 3'h4;

  // Status word layout
  localparam int unsigned ST_RST_BIT = 0;
  localparam int unsigned ST_CAL_BIT = 1;
  localparam int unsigned ST_CP_LSB = 2;
  localparam int unsigned ST_DBL_BIT = 5;
  localparam int unsigned ST_PLL_BIT = 6;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;

  // Effective reference divide factor; bypass gives one
  function automatic logic [3:0] div_factor(input logic [1:0] sel, input logic en);
    logic [3:0] f;
    f = FACTOR_1;
    if (en) begin
      case (sel)
        DIV_SEL_1: f = FACTOR_1;
        DIV_SEL_2: f = FACTOR_2;
        DIV_SEL_4: f = FACTOR_4;
        default: f = FACTOR_8;
      endcase
    end
    return f;
  endfunction

  // Expand byte enables into a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

endpackage

`default_nettype wire

// ### hdl/pll_clock_multiplier_config.sv
// Clock multiplier configuration register with Avalon-MM slave access.
// Assumes calibration status and auto current code come from the PLL core.
//
// What this block does
// - Writing bit 22 one starts divider reset
// - Bits 21:20 select divide 1/2/4/8
// - Divider acts only when bit 17 set
// - Doubling needs both bits 19 and 16
// - Bit 16 zero holds doubler circuit off
// - Bit 18 enables PLL as system clock
// - Feedback field doubled gives total multiplication
// - Feedback field resets to 25
// - Bit 6 zero: automatic pump current
// - Bit 6 one: current from bits 5:3
`default_nettype none

module pll_clock_multiplier_config
  import pll_cfg_pkg::*;
(
  input wire logic i_core_clk, // Core clock, 125 MHz
  input wire logic i_sys_rst, // Synchronous reset, high
  input wire logic [pll_cfg_pkg::ADDR_W-1:0] i_address, // Byte address
  input wire logic i_read, // Read request
  input wire logic i_write, // Write request
  input wire logic [pll_cfg_pkg::BE_W-1:0] i_byteenable, // Byte lanes
  input wire logic [pll_cfg_pkg::DATA_W-1:0] i_writedata, // Write data
  output logic [pll_cfg_pkg::DATA_W-1:0] o_readdata, // Read data
  output logic o_waitrequest, // Stall, high until answer
  input wire logic i_vco_cal_busy, // VCO calibration running
  input wire logic [pll_cfg_pkg::CP_W-1:0] i_cp_auto_code, // Calibrated current
  output logic o_ref_div_reset, // Reference divider reset
  output logic [3:0] o_ref_div_factor, // Effective divide factor
  output logic o_doubler_active, // Doubling in effect
  output logic o_doubler_circuit_en, // Doubler circuit powered
  output logic o_pll_enable, // PLL drives system clock
  output logic [pll_cfg_pkg::FB_W:0] o_pll_mult, // Total multiplication
  output logic o_cp_manual, // Manual current selected
  output logic [pll_cfg_pkg::CP_W-1:0] o_charge_pump_current // Pump current code
);

  bus_state_t state;
  logic [31:0] clock_multiplier_config;
  logic [CP_W-1:0] cp_auto;
  logic req;
  logic hit_cfg;
  logic hit_status;
  logic cfg_wr;
  logic div_trigger;
  logic [31:0] lanes;
  logic [31:0] status_word;
  logic [1:0] div_sel;
  logic div_en;
  logic dbl_en;
  logic dbl_edge;
  logic pll_en;
  logic [FB_W-1:0] fb_n;
  logic cp_man;
  logic [CP_W-1:0] cp_field;

  // Field views of the config word
  assign div_sel = clock_multiplier_config[DIV_SEL_LSB +: 2];
  assign div_en = clock_multiplier_config[DIV_EN_BIT];
  assign dbl_en = clock_multiplier_config[DBL_EN_BIT];
  assign dbl_edge = clock_multiplier_config[DBL_EDGE_BIT];
  assign pll_en = clock_multiplier_config[PLL_EN_BIT];
  assign fb_n = clock_multiplier_config[FB_LSB +: FB_W];
  assign cp_man = clock_multiplier_config[CP_MAN_BIT];
  assign cp_field = clock_multiplier_config[CP_LSB +: CP_W];

  // Request decode, taken only in the idle state
  assign req = (state == BUS_IDLE) && (i_read || i_write);
  assign hit_cfg = (i_address == CFG_ADDR);
  assign hit_status = (i_address == STATUS_ADDR);
  assign cfg_wr = req && i_write && hit_cfg;
  assign lanes = lane_mask(i_byteenable);

  assign div_trigger = cfg_wr && i_byteenable[DIV_RST_LANE] && i_writedata[DIV_RST_BIT];

  // Live state shown to software
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_RST_BIT] = o_ref_div_reset;
    status_word[ST_CAL_BIT] = i_vco_cal_busy;
    status_word[ST_CP_LSB +: CP_W] = o_charge_pump_current;
    status_word[ST_DBL_BIT] = o_doubler_active;
    status_word[ST_PLL_BIT] = o_pll_enable;
  end

  // Bus handshake: one stall cycle, then one answer cycle
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state <= BUS_IDLE;
      o_waitrequest <= 1'b1;
    end else begin
      case (state)
        BUS_IDLE: begin
          if (req) begin
            state <= BUS_ACK;
            o_waitrequest <= 1'b0;
          end
        end
        BUS_ACK: begin
          state <= BUS_IDLE;
          o_waitrequest <= 1'b1;
        end
        default: begin
          state <= BUS_IDLE;
          o_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Read data captured when the request is taken; unmapped reads zero
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_readdata <= 32'h0000_0000;
    end else if (req && i_read) begin
      if (hit_cfg) begin
        o_readdata <= clock_multiplier_config;
      end else if (hit_status) begin
        o_readdata <= status_word;
      end else begin
        o_readdata <= 32'h0000_0000;
      end
    end
  end

  // Config register with byte lanes
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      clock_multiplier_config <= CFG_RESET;
    end else if (cfg_wr) begin
      clock_multiplier_config <= ((clock_multiplier_config & ~lanes) | (i_writedata & lanes))
                                 & CFG_WR_MASK;
    end
  end

  // Divider reset pulse
  div_reset_pulse u_div_reset (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_trigger(div_trigger),
    .o_pulse(o_ref_div_reset)
  );

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_ref_div_factor <= FACTOR_1;
    end else begin
      o_ref_div_factor <= div_factor(div_sel, div_en);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_doubler_active <= 1'b0;
      o_doubler_circuit_en <= 1'b0;
    end else begin
      o_doubler_active <= dbl_en && dbl_edge;
      o_doubler_circuit_en <= dbl_edge;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_pll_enable <= 1'b0;
      o_pll_mult <= {1'b0, 8'h00};
    end else begin
      o_pll_enable <= pll_en;
      o_pll_mult <= {fb_n, 1'b0};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cp_auto <= 3'h0;
    end else if (i_vco_cal_busy && !cp_man) begin
      cp_auto <= i_cp_auto_code;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_cp_manual <= 1'b0;
      o_charge_pump_current <= 3'h0;
    end else begin
      o_cp_manual <= cp_man;
      o_charge_pump_current <= cp_man ? cp_field : cp_auto;
    end
  end

  // Bus answer sequences
  sequence s_taken;
    req;
  endsequence

  sequence s_answer;
    !o_waitrequest ##1 o_waitrequest;
  endsequence

  a_bus_answer: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    s_taken |=> s_answer)
    else $error("bus answer not one cycle after request");

  a_div_reset_start: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    div_trigger |=> o_ref_div_reset ##1 o_ref_div_reset)
    else $error("divider reset did not start");

  a_div_select: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    div_en |=> o_ref_div_factor == (FACTOR_1 << $past(div_sel)))
    else $error("divide factor does not match select");

  a_div_bypass: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !div_en |=> o_ref_div_factor == FACTOR_1)
    else $error("divider not bypassed");

  a_doubler_both: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_doubler_active |-> o_doubler_circuit_en && $past(dbl_en))
    else $error("doubling without both enables");

  a_doubler_edge_off: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !dbl_edge |=> !o_doubler_circuit_en && !o_doubler_active)
    else $error("doubler circuit on with edge bit clear");

  a_pll_follow: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $changed(pll_en) |=> o_pll_enable == $past(pll_en))
    else $error("pll enable does not follow bit");

  a_mult_twice: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !$past(i_sys_rst) |-> o_pll_mult == {$past(fb_n), 1'b0})
    else $error("multiplication not twice feedback value");

  a_fb_reset: assert property (@(posedge i_core_clk)
    $fell(i_sys_rst) |-> fb_n == FB_DEFAULT && !cp_man)
    else $error("feedback field not default after reset");

  a_cp_auto: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_vco_cal_busy && !cp_man) ##1 !cp_man |=> o_charge_pump_current == $past(i_cp_auto_code, 2))
    else $error("automatic current not taken from calibration");

  a_cp_manual: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    cp_man |=> o_cp_manual && o_charge_pump_current == $past(cp_field))
    else $error("manual current not applied");

  a_unused_zero: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (clock_multiplier_config & ~CFG_WR_MASK) == 32'h0000_0000)
    else $error("unused config bits not zero");

endmodule

`default_nettype wire
